// ### bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Register port, master side
   input  wire logic        clk_in,
   input  wire logic [31:0] rd_data_in,
   output var  logic [7:0]  addr_out,
   output var  logic [31:0] wr_data_out,
   output var  logic        wr_out,
   output var  logic        rd_out
);
   initial
   begin
      addr_out = 8'h00;
      wr_data_out = 32'h0;
      wr_out = 1'h0;
      rd_out = 1'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wr_data_out <= d;
      wr_out <= 1'h1;
      @(posedge clk_in);
      wr_out <= 1'h0;
      // Idle data toggles so a stale value is never taken for a write
      wr_data_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'h1;
      @(posedge clk_in);
      rd_out <= 1'h0;
      #1 d = rd_data_in;
   endtask
endmodule
`default_nettype wire

// ### bench/test_key_use_policy.sv
`timescale 1ns/1ps
`default_nettype none
`include "key_use_regs.svh"
module test_key_use_policy;
   import key_use_pkg::*;
   logic clk_in = 1'h0, reset_in = 1'h1, wake_in = 1'h0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic wr, rd, busy, grant, err, trans, auth, cload;
   logic [3:0] ecode, dslot, aslot, cslot;
   logic [15:0] hsel;
   int fails = 0, n_compared = 0, cyc = 0;
   // Rows: selector, command word, expected error code
   logic [51:0] rows [11] = '{
      {16'h0000, 32'h0, 4'h0}, {16'h0000, 32'h0, 4'h2},
      {16'h0000, 32'h5, 4'h0}, {16'h8000, 32'h3, 4'h0},
      {16'h8000, 32'h0, 4'h1}, {16'h000F, 32'h0, 4'h0},
      {16'h000F, 32'h0, 4'h3}, {16'h0123, 32'h4, 4'h0},
      {16'h0003, 32'h2, 4'h6}, {16'h0006, 32'h10001, 4'h5},
      {16'h0007, 32'h1F2, 4'h3}};
   initial forever #20 clk_in = ~clk_in;
   always @(posedge clk_in) if (++cyc > 3000) begin fails++; results(); end
   host_model host (.clk_in(clk_in), .rd_data_in(rdata), .addr_out(addr),
      .wr_data_out(wdata), .wr_out(wr), .rd_out(rd));
   key_use_policy u_key_use_policy (.clk_in(clk_in), .reset_in(reset_in),
      .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
      .rd_data_out(rdata), .wake_in(wake_in), .busy_out(busy),
      .grant_out(grant), .error_out(err), .err_code_out(ecode),
      .transport_out(trans), .data_slot_out(dslot),
      .hash_selector_out(hsel), .auth_ok_out(auth), .auth_slot_out(aslot),
      .copy_load_out(cload), .copy_slot_out(cslot));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmd(logic [15:0] s, logic [31:0] c);
      host.wr(`SEL_OFS, {16'h0, s});
      host.wr(`CMD_OFS, c);
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk_in);
         #1 if (!busy || grant) break;
      end
   endtask
   task automatic results();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'h0;
      host.rd(`STATUS_OFS, d);
      chk("status", 32'h0, d);
      host.wr(`LIMIT_EN_OFS, 32'h8001);
      host.wr(`COUNTER_OFS, 32'h1FFFFE);
      host.wr(`BITMAP_OFS, 32'h1);
      for (int i = 1; i < 4; i++) host.wr(`BITMAP_OFS + 8'(4 * i), 32'h0);
      host.wr(`SECONDARY_OFS, 32'h10);
      host.wr(`READ_KEY_SELECTOR_OFS, 32'h20);
      host.wr(`REQ_RANDOM_OFS, 32'h4);
      host.wr(`AUTH_REQ_OFS, 32'h8);
      host.wr(`PUBKEY_OK_OFS, 32'h80);
      host.wr(`TEMP_KEY_REGISTER_OFS, 32'h1);
      foreach (rows[i])
      begin
         cmd(rows[i][51:36], rows[i][35:4]);
         chk("err_code", rows[i][3:0], ecode);
         chk("grant", rows[i][3:0] == 4'h0, grant);
         chk("error", rows[i][3:0] != 4'h0, err);
         chk("busy", rows[i][3:0] == 4'h0, busy);
         chk("hash_sel", rows[i][51:36], hsel);
         chk("transport", rows[i][51], trans);
         if (!rows[i][51]) chk("slot", rows[i][39:36], dslot);
         if (grant === 1'h1) host.wr(`RESULT_OFS, 32'h1);
      end
      host.rd(`COUNTER_OFS, d);
      chk("counter", 32'h1FFFFF, d);
      host.rd(`BITMAP_OFS, d);
      chk("bitmap", 32'h0, d);
      cmd(16'h0002, 32'h1);
      host.wr(`RESULT_OFS, 32'h1);
      repeat (2) @(posedge clk_in);
      chk("auth_ok", 1'h1, auth);
      chk("auth_slot", 4'h2, aslot);
      cmd(16'h0003, 32'h0);
      chk("auth_use", 1'h0, auth);
      host.wr(`RESULT_OFS, 32'h1);
      cmd(16'h0002, 32'h1);
      host.wr(`RESULT_OFS, 32'h1);
      @(posedge clk_in);
      chk("auth_again", 1'h1, auth);
      wake_in <= 1'h1;
      @(posedge clk_in);
      wake_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      chk("auth_wake", 1'h0, auth);
      cmd(16'h0001, 32'h1);
      host.wr(`RESULT_OFS, 32'h0);
      #1 chk("err_auth", 4'h4, ecode);
      cmd(16'h0004, 32'h10001);
      host.wr(`RESULT_OFS, 32'h1);
      #1 chk("copy_load", 1'h1, cload);
      chk("copy_slot", 4'h5, cslot);
      host.rd(`TEMP_KEY_REGISTER_OFS, d);
      chk("temp_key_register", 4'h3, d[3:0]);
      cmd(16'h0002, 32'h1);
      chk("err_random", 4'h7, ecode);
      cmd(16'h0001, 32'h1);
      host.wr(`RESULT_OFS, 32'h1);
      host.wr(`LOCK_OFS, 32'h1);
      host.wr(`COUNTER_OFS, 32'h0);
      reset_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'h0;
      chk("auth_reset", 1'h0, auth);
      host.rd(`COUNTER_OFS, d);
      chk("count_kept", 32'h1FFFFF, d);
      results();
   end
endmodule
`default_nettype wire

// ### design/key_use_if.sv
`timescale 1ns/1ps
`default_nettype none
interface key_use_if;
   logic         cnt_inc;
   logic         cnt_load;
   logic [20:0]  cnt_load_value;
   logic [20:0]  cnt_value;
   logic         cnt_at_max;
   logic         bm_use;
   logic         bm_load;
   logic [1:0]   bm_word;
   logic [31:0]  bm_load_value;
   logic [127:0] bm_value;
   logic         bm_empty;

   modport ctrl (output cnt_inc, cnt_load, cnt_load_value, bm_use, bm_load,
                 bm_word, bm_load_value,
                 input  cnt_value, cnt_at_max, bm_value, bm_empty);
   modport counter (input  cnt_inc, cnt_load, cnt_load_value,
                    output cnt_value, cnt_at_max);
   modport bitmap (input  bm_use, bm_load, bm_word, bm_load_value,
                   output bm_value, bm_empty);
endinterface
`default_nettype wire

// ### design/key_use_pkg.sv
package key_use_pkg;
   typedef enum logic [3:0] {
      OP_OTHER,
      OP_MAC_CHECK,
      OP_VERIFY,
      OP_DIGEST_GEN,
      OP_KEYGEN,
      OP_READ,
      OP_WRITE
   } op_e;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CHECK,
      ST_COMMIT,
      ST_GRANT
   } state_e;
endpackage

// ### design/key_use_policy.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "key_use_regs.svh"
module key_use_policy
   import key_use_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wr_data_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output var  logic [31:0] rd_data_out,
   // Power events
   input  wire logic        wake_in,
   // Command status
   output var  logic        busy_out,
   output var  logic        grant_out,
   output var  logic        error_out,
   output var  logic [3:0]  err_code_out,
   output var  logic        transport_out,
   output var  logic [3:0]  data_slot_out,
   output var  logic [15:0] hash_selector_out,
   // Authorization and copy
   output var  logic        auth_ok_out,
   output var  logic [3:0]  auth_slot_out,
   output var  logic        copy_load_out,
   output var  logic [3:0]  copy_slot_out
);
   key_use_if lim ();

   use_counter u_counter (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .bus      (lim.counter)
   );

   use_bitmap u_bitmap (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .bus      (lim.bitmap)
   );

   // Command and configuration state
   state_e      state_q,  state_d;
   op_e         op_q,     op_d;
   logic [15:0] sel_q,    sel_d;
   logic [3:0]  second_q, second_d;
   logic        valid8_q, valid8_d;
   logic [7:0]  mode_q,   mode_d;
   logic [15:0] limit_en_q,  limit_en_d;
   logic [15:0] read_key_selector_q,   read_key_selector_d;
   logic [15:0] req_rand_q,  req_rand_d;
   logic [15:0] auth_req_q,  auth_req_d;
   logic [15:0] second_map_q, second_map_d;
   logic [15:0] pubkey_ok_q, pubkey_ok_d;
   logic [3:0]  tk_q,     tk_d;
   logic        lock_q,   lock_d;
   logic        need_cnt_q, need_cnt_d;
   logic        need_bm_q,  need_bm_d;
   // Output state
   logic [31:0] rd_data_q, rd_data_d;
   logic        busy_q,    busy_d;
   logic        grant_q,   grant_d;
   logic        error_q,   error_d;
   logic [3:0]  err_q,     err_d;
   logic        transport_q, transport_d;
   logic [3:0]  slot_q,    slot_d;
   logic [15:0] hash_sel_q, hash_sel_d;
   logic        auth_ok_q, auth_ok_d;
   logic [3:0]  auth_slot_q, auth_slot_d;
   logic        copy_q,    copy_d;
   logic [3:0]  copy_slot_q, copy_slot_d;

   // Decode of the captured command
   logic       is_transport;
   logic [3:0] slot;
   logic [3:0] target;
   logic       copy_mode;
   logic       bypass;
   logic       auth_cmd;
   logic       dual;
   logic       cnt_hit;
   logic       bm_hit;
   logic [3:0] fault;
   logic       wr_cmd;
   logic       wr_result;

   always_comb
   begin
      is_transport = (sel_q >= `TRANSPORT_BASE);
      slot         = sel_q[3:0];
      target       = second_map_q[slot] ? slot + 4'h1 : slot;
      copy_mode    = (op_q == OP_MAC_CHECK) && (mode_q == `COPY_MODE);
      bypass       = (op_q == OP_KEYGEN) || (op_q == OP_READ)
                     || (op_q == OP_WRITE)
                     || (copy_mode && target == slot);
      auth_cmd     = ((op_q == OP_MAC_CHECK) && !copy_mode)
                     || ((op_q == OP_VERIFY) && !valid8_q);
      dual         = (op_q == OP_VERIFY) && valid8_q;
      cnt_hit      = !bypass && !is_transport
                     && ((slot <= `LAST_CNT_SLOT && limit_en_q[slot])
                     || (dual && second_q <= `LAST_CNT_SLOT
                         && limit_en_q[second_q]));
      bm_hit       = !bypass && limit_en_q[`SINGLE_USE_SLOT]
                     && ((!is_transport && slot == `SINGLE_USE_SLOT)
                     || (dual && second_q == `SINGLE_USE_SLOT));
      // Checks run in priority order; the first failure wins
      if (is_transport && op_q != OP_DIGEST_GEN)
         fault = `ERR_TRANSPORT;
      else if (copy_mode && (!read_key_selector_q[target] || !tk_q[`TK_VALID]
               || tk_q[`TK_NONCE_SRC]))
         fault = `ERR_COPY;
      else if (op_q == OP_VERIFY && !is_transport && !pubkey_ok_q[slot])
         fault = `ERR_KEY;
      else if (auth_cmd && req_rand_q[slot] && tk_q[`TK_NONCE_SRC])
         fault = `ERR_RANDOM;
      else if (cnt_hit && lim.cnt_at_max)
         fault = `ERR_COUNT;
      else if (bm_hit && lim.bm_empty)
         fault = `ERR_BITMAP;
      else
         fault = `ERR_NONE;
      wr_cmd    = wr_in && addr_in == `CMD_OFS;
      wr_result = wr_in && addr_in == `RESULT_OFS;
   end

   // Limit uses happen only in COMMIT, before the grant; loads follow unlocked writes to the counter and bitmap registers
   always_comb
   begin
      lim.cnt_inc        = (state_q == ST_COMMIT) && need_cnt_q;
      lim.bm_use         = (state_q == ST_COMMIT) && need_bm_q;
      lim.cnt_load       = wr_in && !lock_q && addr_in == `COUNTER_OFS;
      lim.cnt_load_value = wr_data_in[20:0];
      lim.bm_load        = wr_in && !lock_q
                           && addr_in[7:4] == `BITMAP_OFS >> 4;
      lim.bm_word        = addr_in[3:2];
      lim.bm_load_value  = wr_data_in;
   end

   always_comb
   begin
      state_d      = state_q;
      op_d         = op_q;
      sel_d        = sel_q;
      second_d     = second_q;
      valid8_d     = valid8_q;
      mode_d       = mode_q;
      limit_en_d   = limit_en_q;
      read_key_selector_d    = read_key_selector_q;
      req_rand_d   = req_rand_q;
      auth_req_d   = auth_req_q;
      second_map_d = second_map_q;
      pubkey_ok_d  = pubkey_ok_q;
      tk_d         = tk_q;
      lock_d       = lock_q;
      need_cnt_d   = need_cnt_q;
      need_bm_d    = need_bm_q;
      grant_d      = grant_q;
      error_d      = error_q;
      err_d        = err_q;
      transport_d  = transport_q;
      slot_d       = slot_q;
      hash_sel_d   = hash_sel_q;
      auth_ok_d    = auth_ok_q;
      auth_slot_d  = auth_slot_q;
      copy_d       = 1'b0;
      copy_slot_d  = copy_slot_q;
      rd_data_d    = 32'h00000000;

      // Configuration freezes once locked
      if (wr_in && !lock_q)
      begin
         case (addr_in)
            `LIMIT_EN_OFS:   limit_en_d   = wr_data_in[15:0];
            `READ_KEY_SELECTOR_OFS:    read_key_selector_d    = wr_data_in[15:0];
            `REQ_RANDOM_OFS: req_rand_d   = wr_data_in[15:0];
            `AUTH_REQ_OFS:   auth_req_d   = wr_data_in[15:0];
            `SECONDARY_OFS:  second_map_d = wr_data_in[15:0];
            `PUBKEY_OK_OFS:  pubkey_ok_d  = wr_data_in[15:0];
            default:         lock_d       = lock_q;
         endcase
      end
      if (wr_in && addr_in == `LOCK_OFS && wr_data_in[0])
         lock_d = 1'b1;
      if (wr_in && addr_in == `TEMP_KEY_REGISTER_OFS)
         tk_d = wr_data_in[3:0];
      if (wr_in && addr_in == `SEL_OFS && state_q == ST_IDLE)
         sel_d = wr_data_in[15:0];

      // A wake clears authorization; a same-cycle set below still wins
      if (wake_in)
         auth_ok_d = 1'b0;

      case (state_q)
         ST_IDLE:
         begin
            if (wr_cmd)
            begin
               op_d     = op_e'(wr_data_in[`CMD_OP_LSB +: 4]);
               second_d = wr_data_in[`CMD_SECOND_LSB +: 4];
               valid8_d = wr_data_in[`CMD_VALIDATE];
               mode_d   = wr_data_in[`CMD_MODE_LSB +: 8];
               grant_d  = 1'b0;
               error_d  = 1'b0;
               err_d    = `ERR_NONE;
               state_d  = ST_CHECK;
            end
         end
         ST_CHECK:
         begin
            transport_d = is_transport;
            slot_d      = slot;
            hash_sel_d  = sel_q;
            need_cnt_d  = cnt_hit;
            need_bm_d   = bm_hit;
            if (!is_transport && auth_req_q[slot] && !auth_cmd)
               auth_ok_d = 1'b0;
            if (fault != `ERR_NONE)
            begin
               error_d = 1'b1;
               err_d   = fault;
               state_d = ST_IDLE;
            end
            else
               state_d = ST_COMMIT;
         end
         ST_COMMIT:
         begin
            grant_d = 1'b1;
            state_d = ST_GRANT;
         end
         ST_GRANT:
         begin
            if (wr_result)
            begin
               grant_d = 1'b0;
               if (wr_data_in[0] && auth_cmd)
               begin
                  auth_ok_d   = 1'b1;
                  auth_slot_d = slot_q;
               end
               else if (wr_data_in[0] && copy_mode)
               begin
                  copy_d      = 1'b1;
                  copy_slot_d = target;
                  tk_d        = 4'b0011;
               end
               else if (!wr_data_in[0] && (auth_cmd || copy_mode))
               begin
                  error_d = 1'b1;
                  err_d   = `ERR_AUTH;
               end
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      busy_d = state_d != ST_IDLE;

      if (rd_in)
      begin
         case (addr_in)
            `SEL_OFS:        rd_data_d = {16'h0000, sel_q};
            `STATUS_OFS:     rd_data_d = {4'h0, auth_slot_q, 3'b000,
                                          auth_ok_q, 4'h0, err_q, 3'b000,
                                          transport_q, slot_q, grant_q,
                                          error_q, lock_q,
                                          state_q != ST_IDLE};
            `LIMIT_EN_OFS:   rd_data_d = {16'h0000, limit_en_q};
            `READ_KEY_SELECTOR_OFS:    rd_data_d = {16'h0000, read_key_selector_q};
            `REQ_RANDOM_OFS: rd_data_d = {16'h0000, req_rand_q};
            `AUTH_REQ_OFS:   rd_data_d = {16'h0000, auth_req_q};
            `SECONDARY_OFS:  rd_data_d = {16'h0000, second_map_q};
            `PUBKEY_OK_OFS:  rd_data_d = {16'h0000, pubkey_ok_q};
            `COUNTER_OFS:    rd_data_d = {11'h000, lim.cnt_value};
            `TEMP_KEY_REGISTER_OFS:    rd_data_d = {28'h0000000, tk_q};
            `LOCK_OFS:       rd_data_d = {31'h00000000, lock_q};
            default:
            begin
               if (addr_in[7:4] == `BITMAP_OFS >> 4)
                  rd_data_d = lim.bm_value[{addr_in[3:2], 5'h00} +: 32];
               else
                  rd_data_d = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         state_q      <= ST_IDLE;
         op_q         <= OP_OTHER;
         sel_q        <= 16'h0000;
         second_q     <= 4'h0;
         valid8_q     <= 1'b0;
         mode_q       <= 8'h00;
         limit_en_q   <= `SETTINGS_RESET;
         read_key_selector_q    <= `SETTINGS_RESET;
         req_rand_q   <= `SETTINGS_RESET;
         auth_req_q   <= `SETTINGS_RESET;
         second_map_q <= `SETTINGS_RESET;
         pubkey_ok_q  <= `SETTINGS_RESET;
         tk_q         <= `TK_RESET;
         lock_q       <= 1'b0;
         need_cnt_q   <= 1'b0;
         need_bm_q    <= 1'b0;
         rd_data_q    <= 32'h00000000;
         busy_q       <= 1'b0;
         grant_q      <= 1'b0;
         error_q      <= 1'b0;
         err_q        <= `ERR_NONE;
         transport_q  <= 1'b0;
         slot_q       <= 4'h0;
         hash_sel_q   <= 16'h0000;
         auth_ok_q    <= 1'b0;
         auth_slot_q  <= 4'h0;
         copy_q       <= 1'b0;
         copy_slot_q  <= 4'h0;
      end
      else
      begin
         state_q      <= state_d;
         op_q         <= op_d;
         sel_q        <= sel_d;
         second_q     <= second_d;
         valid8_q     <= valid8_d;
         mode_q       <= mode_d;
         limit_en_q   <= limit_en_d;
         read_key_selector_q    <= read_key_selector_d;
         req_rand_q   <= req_rand_d;
         auth_req_q   <= auth_req_d;
         second_map_q <= second_map_d;
         pubkey_ok_q  <= pubkey_ok_d;
         tk_q         <= tk_d;
         lock_q       <= lock_d;
         need_cnt_q   <= need_cnt_d;
         need_bm_q    <= need_bm_d;
         rd_data_q    <= rd_data_d;
         busy_q       <= busy_d;
         grant_q      <= grant_d;
         error_q      <= error_d;
         err_q        <= err_d;
         transport_q  <= transport_d;
         slot_q       <= slot_d;
         hash_sel_q   <= hash_sel_d;
         auth_ok_q    <= auth_ok_d;
         auth_slot_q  <= auth_slot_d;
         copy_q       <= copy_d;
         copy_slot_q  <= copy_slot_d;
      end
   end

   assign rd_data_out       = rd_data_q;
   assign busy_out          = busy_q;
   assign grant_out         = grant_q;
   assign error_out         = error_q;
   assign err_code_out      = err_q;
   assign transport_out     = transport_q;
   assign data_slot_out     = slot_q;
   assign hash_selector_out = hash_sel_q;
   assign auth_ok_out       = auth_ok_q;
   assign auth_slot_out     = auth_slot_q;
   assign copy_load_out     = copy_q;
   assign copy_slot_out     = copy_slot_q;

   sequence check_pass;
      state_q == ST_CHECK && fault == `ERR_NONE;
   endsequence
   sequence commit_then_grant;
      state_q == ST_COMMIT ##1 grant_q;
   endsequence

   grant_after_update_a: assert property (@(posedge clk_in)
      disable iff (reset_in) check_pass |=> commit_then_grant)
      else $error("grant did not follow the limit update");
   count_limit_err_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      state_q == ST_CHECK && cnt_hit && lim.cnt_at_max
      |=> error_q && !lim.cnt_inc ##1 !lim.cnt_inc)
      else $error("limited use at terminal count was not refused");
   transport_only_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      grant_q && transport_q |-> op_q == OP_DIGEST_GEN)
      else $error("transport key granted to wrong command");
   bitmap_empty_err_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      state_q == ST_CHECK && bm_hit && lim.bm_empty && fault == `ERR_BITMAP
      |=> error_q && err_q == `ERR_BITMAP && !lim.bm_use)
      else $error("empty bitmap did not refuse slot 15");
   bypass_cmds_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      state_q == ST_COMMIT && (op_q == OP_READ || op_q == OP_WRITE
      || op_q == OP_KEYGEN) |-> !lim.cnt_inc && !lim.bm_use)
      else $error("bypassing command consumed a limit");
   copy_flags_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      copy_q |-> tk_q == 4'b0011 && copy_slot_q == $past(target))
      else $error("copy left wrong temp key flags");
   auth_record_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      state_q == ST_GRANT && wr_result && wr_data_in[0] && auth_cmd
      |=> auth_ok_q && auth_slot_q == $past(slot_q))
      else $error("authorization not recorded");
   wake_clear_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      wake_in && !(state_q == ST_GRANT && wr_result) |=> !auth_ok_q)
      else $error("wake did not clear authorization");
   hash_sel_a: assert property (@(posedge clk_in)
      disable iff (reset_in)
      state_q == ST_CHECK |=> hash_sel_q == $past(sel_q)
      && slot_q == $past(sel_q[3:0]))
      else $error("selector not passed whole to hashing");
endmodule
`default_nettype wire

// ### design/key_use_regs.svh
`ifndef KEY_USE_REGS_SVH
`define KEY_USE_REGS_SVH

// Register byte offsets
`define CMD_OFS         8'h00
`define SEL_OFS         8'h04
`define RESULT_OFS      8'h08
`define STATUS_OFS      8'h0C
`define LIMIT_EN_OFS    8'h10
`define READ_KEY_SELECTOR_OFS     8'h14
`define REQ_RANDOM_OFS  8'h18
`define AUTH_REQ_OFS    8'h1C
`define SECONDARY_OFS   8'h20
`define PUBKEY_OK_OFS   8'h24
`define COUNTER_OFS     8'h28
`define TEMP_KEY_REGISTER_OFS     8'h2C
`define LOCK_OFS        8'h30
`define BITMAP_OFS      8'h40

// Command register fields
`define CMD_OP_LSB      0
`define CMD_SECOND_LSB  4
`define CMD_VALIDATE    8
`define CMD_MODE_LSB    16

// Temporary key flag bits
`define TK_VALID        0
`define TK_NONCE_SRC    1
`define TK_DIGEST_DATA  2
`define TK_MAC_BLOCK    3

// Reset values and limits
`define TK_RESET        4'h0
`define SETTINGS_RESET  16'h0000
`define CNT_MAX         21'h1FFFFF
`define TRANSPORT_BASE  16'h8000
`define COPY_MODE       8'h01
`define LAST_CNT_SLOT   4'hE
`define SINGLE_USE_SLOT 4'hF

// Error codes
`define ERR_NONE        4'h0
`define ERR_TRANSPORT   4'h1
`define ERR_COUNT       4'h2
`define ERR_BITMAP      4'h3
`define ERR_AUTH        4'h4
`define ERR_COPY        4'h5
`define ERR_KEY         4'h6
`define ERR_RANDOM      4'h7

`endif

// ### design/use_bitmap.sv
`timescale 1ns/1ps
`default_nettype none
`include "key_use_regs.svh"
module use_bitmap
   import key_use_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   key_use_if.bitmap bus
);
   logic [127:0] bits_q;
   logic [127:0] bits_d;
   logic [6:0]   pos;
   logic         found;
   logic [3:0]   loaded_q;
   logic [3:0]   loaded_d;

   // Scan byte 0 bit 7 first, then downward, then the next byte
   always_comb
   begin
      logic [6:0] k;
      k     = 7'h00;
      pos   = 7'h00;
      found = 1'b0;
      for (int i = 0; i < 128; i++)
      begin
         k = 7'(i);
         if (!found && bits_q[{k[6:3], ~k[2:0]}])
         begin
            found = 1'b1;
            pos   = {k[6:3], ~k[2:0]};
         end
      end
   end

   // No reset: consumed bits return only through a load, only one bit moves per use
   always_comb
   begin
      bits_d = bits_q;
      // Words power up unknown; the hold check waits until all are loaded
      loaded_d = loaded_q;
      if (reset_in)
         loaded_d = 4'h0;
      else if (bus.bm_load)
         loaded_d[bus.bm_word] = 1'b1;
      if (bus.bm_load)
         bits_d[{bus.bm_word, 5'h00} +: 32] = bus.bm_load_value;
      else if (bus.bm_use && found)
         bits_d[pos] = 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      bits_q   <= bits_d;
      loaded_q <= loaded_d;
   end

   assign bus.bm_value = bits_q;
   assign bus.bm_empty = !found;

   one_bit_a: assert property (@(posedge clk_in) disable iff (reset_in)
      bus.bm_use && !bus.bm_load && found
      |=> $countones(bits_q ^ $past(bits_q)) == 1 && (bits_q & ~$past(bits_q)) == '0)
      else $error("bitmap update changed more than one bit");
   bitmap_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
      &loaded_q && !bus.bm_use && !bus.bm_load |=> bits_q == $past(bits_q))
      else $error("bitmap changed without a use");
endmodule
`default_nettype wire

// ### design/use_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "key_use_regs.svh"
module use_counter
   import key_use_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   key_use_if.counter bus
);
   logic [20:0] count_q;
   logic [20:0] count_d;
   logic        loaded_q;
   logic        loaded_d;

   // Nonvolatile count: no reset, only personalization load or increment
   always_comb
   begin
      count_d = count_q;
      // The stored count powers up unknown; the no-decrease check waits for a load
      loaded_d = !reset_in && (loaded_q || bus.cnt_load);
      if (bus.cnt_load)
         count_d = bus.cnt_load_value;
      else if (bus.cnt_inc && count_q != `CNT_MAX)
         count_d = count_q + 21'h000001;
   end

   always_ff @(posedge clk_in)
   begin
      count_q  <= count_d;
      loaded_q <= loaded_d;
   end

   assign bus.cnt_value  = count_q;
   assign bus.cnt_at_max = (count_q == `CNT_MAX);

   no_decrease_a: assert property (@(posedge clk_in) disable iff (reset_in)
      loaded_q && !bus.cnt_load |=> count_q >= $past(count_q))
      else $error("counter decreased");
   count_step_a: assert property (@(posedge clk_in) disable iff (reset_in)
      bus.cnt_inc && !bus.cnt_load && !bus.cnt_at_max
      |=> count_q == $past(count_q) + 21'h000001)
      else $error("counter did not step by one");
endmodule
`default_nettype wire
